// [rtl/oms_i2c_port.sv]
// Purpose: Two-wire serial register port, 16-bit words, high byte first
// Assumes: sclIn and sdaIn are synchronised here; open-drain data pin
// Notes: Address auto-increments except on the FIFO data register
`timescale 1ns/10ps
module oms_i2c_port #(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [15:0] rdData,
  output logic sdaOut,
  output logic sdaOe,
  output logic wrStrobe,
  output logic [7:0] regAddr,
  output logic [15:0] wrData,
  output logic rdPop
);
  oms_pkg::oms_port_state_t state_q;
  logic sclM_q, sclS_q, sclD_q, sdaM_q, sdaS_q, sdaD_q;
  logic ack_q, bytePos_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [15:0] txWord_q;
  logic sclRise, sclFall, startC, stopC;

  function automatic logic [7:0] nextAddr(input logic [7:0] a);
    nextAddr = (a == oms_pkg::ADDR_FIFO) ? a : 8'(a + 8'h01);
  endfunction

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {sclM_q, sclS_q, sclD_q} <= 3'h7;
      {sdaM_q, sdaS_q, sdaD_q} <= 3'h7;
    end else begin
      {sclM_q, sclS_q, sclD_q} <= {sclIn, sclM_q, sclS_q};
      {sdaM_q, sdaS_q, sdaD_q} <= {sdaIn, sdaM_q, sdaS_q};
    end
  end

  assign sclRise = sclS_q & ~sclD_q;
  assign sclFall = ~sclS_q & sclD_q;
  assign startC = sclS_q & sclD_q & sdaD_q & ~sdaS_q;
  assign stopC = sclS_q & sclD_q & ~sdaD_q & sdaS_q;

  // Only ever pulls low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= oms_pkg::PS_IDLE;
      ack_q <= 1'b0;
      bytePos_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      txWord_q <= 16'h0000;
      sdaOe <= 1'b0;
      wrStrobe <= 1'b0;
      rdPop <= 1'b0;
      regAddr <= 8'h00;
      wrData <= 16'h0000;
    end else begin
      wrStrobe <= 1'b0;
      rdPop <= 1'b0;
      if (wrStrobe) begin
        regAddr <= nextAddr(regAddr);
      end
      if (stopC) begin
        state_q <= oms_pkg::PS_IDLE;
        ack_q <= 1'b0;
        sdaOe <= 1'b0;
      end else if (startC) begin
        state_q <= oms_pkg::PS_ADDR;
        ack_q <= 1'b0;
        sdaOe <= 1'b0;
        cnt_q <= 4'h0;
      end else if (sclRise) begin
        if (!ack_q && cnt_q < 4'h8 && state_q != oms_pkg::PS_IDLE
            && state_q != oms_pkg::PS_RDATA) begin
          sh_q <= {sh_q[6:0], sdaS_q};
          cnt_q <= cnt_q + 4'h1;
        end else if (state_q == oms_pkg::PS_RDATA && cnt_q == 4'h9) begin
          // Master not-acknowledge ends the read burst
          if (sdaS_q) begin
            state_q <= oms_pkg::PS_IDLE;
          end else begin
            cnt_q <= 4'ha;
          end
          if (bytePos_q) begin
            rdPop <= 1'b1;
            regAddr <= nextAddr(regAddr);
          end
          bytePos_q <= ~bytePos_q;
        end
      end else if (sclFall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          if (state_q == oms_pkg::PS_RDATA) begin
            txWord_q <= rdData;
            sdaOe <= ~rdData[15];
            cnt_q <= 4'h1;
            bytePos_q <= 1'b0;
          end else begin
            sdaOe <= 1'b0;
            cnt_q <= 4'h0;
          end
        end else begin
          unique case (state_q)
            oms_pkg::PS_IDLE: begin
            end
            oms_pkg::PS_ADDR: begin
              if (cnt_q == 4'h8) begin
                if (sh_q[7:1] == DEV_ADDR) begin
                  ack_q <= 1'b1;
                  sdaOe <= 1'b1;
                  state_q <= sh_q[0] ? oms_pkg::PS_RDATA : oms_pkg::PS_REG;
                end else begin
                  state_q <= oms_pkg::PS_IDLE;
                end
              end
            end
            oms_pkg::PS_REG: begin
              if (cnt_q == 4'h8) begin
                regAddr <= sh_q;
                ack_q <= 1'b1;
                sdaOe <= 1'b1;
                bytePos_q <= 1'b0;
                state_q <= oms_pkg::PS_WDATA;
              end
            end
            oms_pkg::PS_WDATA: begin
              if (cnt_q == 4'h8) begin
                ack_q <= 1'b1;
                sdaOe <= 1'b1;
                bytePos_q <= ~bytePos_q;
                if (bytePos_q) begin
                  wrData[7:0] <= sh_q;
                  wrStrobe <= 1'b1;
                end else begin
                  wrData[15:8] <= sh_q;
                end
              end
            end
            oms_pkg::PS_RDATA: begin
              if (cnt_q < 4'h8) begin
                sdaOe <= ~txWord_q[{~bytePos_q, ~cnt_q[2:0]}];
                cnt_q <= cnt_q + 4'h1;
              end else if (cnt_q == 4'h8) begin
                sdaOe <= 1'b0;
                cnt_q <= 4'h9;
              end else if (cnt_q == 4'ha) begin
                // Fresh word fetched only at a word boundary
                if (!bytePos_q) begin
                  txWord_q <= rdData;
                  sdaOe <= ~rdData[15];
                end else begin
                  sdaOe <= ~txWord_q[7];
                end
                cnt_q <= 4'h1;
              end
            end
          endcase
        end
      end
    end
  end
endmodule

// [rtl/oms_mode_sequencer.sv]
// Purpose: Operating-mode sequencer with sample routing and a 128-byte FIFO
// Assumes: Sample inputs are one-cycle pulses from the converter path
// Notes: Mode changes happen only on ticks of the divided slow sample clock
`timescale 1ns/10ps
// Function
// - Powers up in standby; mode register reads the standby code.
// - Host sets clock-enable bit; the slow sample clock then starts.
// - No mode transition while the slow sample clock is stopped.
// - Writing program code to mode register enters program mode.
// - Clock enable and program request in any order; change waits for both.
// - Writing normal code starts periodic sampling.
// - Shutdown goes through program mode, then standby code returns standby.
// - Writing 0x00FF to status clears all interrupt flags.
// - With FIFO access bit set, writing 0x80FF empties FIFO and clears flags.
// - Clock enable cleared outside standby locks the mode machine for good.
// - Each slot routes samples to FIFO or data register; slot B's choice also depends on slot A.
// - 128-byte FIFO holds samples from either or both slots.
// - Format register selects whether each slot places its samples in the FIFO: a nonzero 3-bit field routes the slot.
// - Three LED drivers each have a 3-bit slew field, bits 6 to 4.
// - Both slots feed FIFO only when averaging factors match.
// - Packet written only if the whole packet fits; else dropped.
// - Status upper byte reports FIFO byte count.
module oms_mode_sequencer #(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic slotAValid,
  input wire logic [15:0] slotASample,
  input wire logic slotBValid,
  input wire logic [15:0] slotBSample,
  input wire logic [2:0] slotAAvgFactor,
  input wire logic [2:0] slotBAvgFactor,
  output logic [1:0] modeCode,
  output logic sampleClockRunning,
  output logic lockedUp,
  output logic [2:0] ledSlewOne,
  output logic [2:0] ledSlewTwo,
  output logic [2:0] ledSlewThree
);
  logic wrStrobe, rdPop;
  logic [7:0] regAddr;
  logic [15:0] wrData, rdData;

  oms_pkg::oms_mode_t mode_q;
  logic [1:0] modeReq_q;
  logic [15:0] fmt_q, led1_q, led2_q, led3_q, clkCtl_q, dataCtl_q;
  logic [15:0] dataA_q, dataB_q, pendA_q;
  logic [7:0] flags_q;
  logic [11:0] div_q;
  logic slowTick_q, stuck_q;
  logic [15:0] fifoMem_q [oms_pkg::FIFO_WORDS];
  logic [5:0] wrPtr_q, rdPtr_q;
  logic [6:0] count_q;

  logic wrStatus, wrMode, clkEn, fifoAcc, fifoClear, popFifo;
  logic routeA, routeB, pushEn, pushTwo;
  logic [15:0] pushW0, pushW1;
  logic [6:0] pktWords;
  logic [7:0] levelBytes;

  function automatic logic isWr(input logic s, input logic [7:0] a, input logic [7:0] r);
    isWr = s && (a == r);
  endfunction

  oms_i2c_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .sys_clk(sys_clk),
    .reset(reset),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .rdData(rdData),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .wrStrobe(wrStrobe),
    .regAddr(regAddr),
    .wrData(wrData),
    .rdPop(rdPop)
  );

  assign wrStatus = isWr(wrStrobe, regAddr, oms_pkg::ADDR_STATUS);
  assign wrMode = isWr(wrStrobe, regAddr, oms_pkg::ADDR_MODE);
  assign clkEn = clkCtl_q[oms_pkg::CLK_EN_BIT];
  assign fifoAcc = dataCtl_q[oms_pkg::FIFO_ACC_BIT];
  assign fifoClear = wrStatus && wrData[oms_pkg::FIFO_CLR_BIT] && fifoAcc;
  assign popFifo = rdPop && (regAddr == oms_pkg::ADDR_FIFO) && fifoAcc
                   && (count_q != 7'h00);
  assign levelBytes = {count_q, 1'b0};

  // Configuration registers; ordering of these writes is free
  // config writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fmt_q <= oms_pkg::REG_RESET;
      led1_q <= oms_pkg::REG_RESET;
      led2_q <= oms_pkg::REG_RESET;
      led3_q <= oms_pkg::REG_RESET;
      clkCtl_q <= oms_pkg::REG_RESET;
      dataCtl_q <= oms_pkg::REG_RESET;
      modeReq_q <= oms_pkg::MODE_STANDBY;
    end else if (wrStrobe) begin
      unique case (regAddr)
        oms_pkg::ADDR_FMT: fmt_q <= wrData;
        oms_pkg::ADDR_LED1: led1_q <= wrData;
        oms_pkg::ADDR_LED2: led2_q <= wrData;
        oms_pkg::ADDR_LED3: led3_q <= wrData;
        oms_pkg::ADDR_CLKCTL: clkCtl_q <= wrData;
        oms_pkg::ADDR_DATACTL: dataCtl_q <= wrData;
        oms_pkg::ADDR_MODE: modeReq_q <= wrData[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ledSlewOne <= 3'h0;
      ledSlewTwo <= 3'h0;
      ledSlewThree <= 3'h0;
    end else begin
      ledSlewOne <= led1_q[oms_pkg::SLEW_MSB:oms_pkg::SLEW_LSB];
      ledSlewTwo <= led2_q[oms_pkg::SLEW_MSB:oms_pkg::SLEW_LSB];
      ledSlewThree <= led3_q[oms_pkg::SLEW_MSB:oms_pkg::SLEW_LSB];
    end
  end

  // Slow sample clock as a tick; keeps running after lock-up while clock enable is set
  // slow clock start
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_q <= 12'h000;
      slowTick_q <= 1'b0;
      sampleClockRunning <= 1'b0;
    end else begin
      sampleClockRunning <= clkEn;
      slowTick_q <= 1'b0;
      if (!clkEn) begin
        div_q <= 12'h000;
      end else if (div_q == oms_pkg::SLOW_DIV_LAST) begin
        div_q <= 12'h000;
        slowTick_q <= 1'b1;
      end else begin
        div_q <= div_q + 12'h001;
      end
    end
  end

  // Losing the clock outside standby strands the machine; only reset frees it
  // lock-up latch
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stuck_q <= 1'b0;
    end else if (clkEn == 1'b0 && mode_q != oms_pkg::MS_STANDBY) begin
      stuck_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_q <= oms_pkg::MS_STANDBY;
    end else if (slowTick_q && !stuck_q) begin
      unique case (mode_q)
        oms_pkg::MS_STANDBY: begin
          if (modeReq_q == oms_pkg::MODE_PROGRAM) begin
            mode_q <= oms_pkg::MS_PROGRAM;
          end
        end
        oms_pkg::MS_PROGRAM: begin
          if (modeReq_q == oms_pkg::MODE_NORMAL) begin
            mode_q <= oms_pkg::MS_NORMAL;
          end else if (modeReq_q == oms_pkg::MODE_STANDBY) begin
            mode_q <= oms_pkg::MS_STANDBY;
          end
        end
        oms_pkg::MS_NORMAL: begin
          if (modeReq_q == oms_pkg::MODE_PROGRAM) begin
            mode_q <= oms_pkg::MS_PROGRAM;
          end
        end
        default: mode_q <= oms_pkg::MS_STANDBY;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      modeCode <= oms_pkg::MODE_STANDBY;
      lockedUp <= 1'b0;
    end else begin
      lockedUp <= stuck_q;
      unique case (mode_q)
        oms_pkg::MS_PROGRAM: modeCode <= oms_pkg::MODE_PROGRAM;
        oms_pkg::MS_NORMAL: modeCode <= oms_pkg::MODE_NORMAL;
        default: modeCode <= oms_pkg::MODE_STANDBY;
      endcase
    end
  end

  always_comb begin
    routeA = fmt_q[oms_pkg::FMT_A_MSB:oms_pkg::FMT_A_LSB] != 3'h0;
    routeB = (fmt_q[oms_pkg::FMT_B_MSB:oms_pkg::FMT_B_LSB] != 3'h0)
             && (!routeA || slotAAvgFactor == slotBAvgFactor);
    pushEn = 1'b0;
    pushTwo = 1'b0;
    pushW0 = slotASample;
    pushW1 = slotBSample;
    if (mode_q == oms_pkg::MS_NORMAL) begin
      if (slotAValid && routeA && !routeB) begin
        pushEn = 1'b1;
      end else if (slotBValid && routeB) begin
        pushEn = 1'b1;
        pushTwo = routeA;
        pushW0 = routeA ? pendA_q : slotBSample;
      end
    end
    pktWords = pushTwo ? 7'h02 : 7'h01;
  end

  // Slot A held until slot B completes the packet
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pendA_q <= 16'h0000;
    end else if (slotAValid) begin
      pendA_q <= slotASample;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (pushEn && (count_q + pktWords <= oms_pkg::FIFO_WORDS_W) && !fifoClear) begin
      fifoMem_q[wrPtr_q] <= pushW0;
      if (pushTwo) begin
        fifoMem_q[6'(wrPtr_q + 6'h01)] <= pushW1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= 6'h00;
      rdPtr_q <= 6'h00;
      count_q <= 7'h00;
    end else if (fifoClear) begin
      wrPtr_q <= 6'h00;
      rdPtr_q <= 6'h00;
      count_q <= 7'h00;
    end else begin
      if (pushEn && (count_q + pktWords <= oms_pkg::FIFO_WORDS_W)) begin
        wrPtr_q <= 6'(wrPtr_q + pktWords[5:0]);
        count_q <= 7'(count_q + pktWords - {6'h00, popFifo});
      end else begin
        count_q <= 7'(count_q - {6'h00, popFifo});
      end
      if (popFifo) begin
        rdPtr_q <= rdPtr_q + 6'h01;
      end
    end
  end

  // Data registers freeze while software holds them
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dataA_q <= 16'h0000;
      dataB_q <= 16'h0000;
    end else if (mode_q == oms_pkg::MS_NORMAL) begin
      if (slotAValid && !routeA && !dataCtl_q[oms_pkg::HOLD_A_BIT]) begin
        dataA_q <= slotASample;
      end
      if (slotBValid && !routeB && !dataCtl_q[oms_pkg::HOLD_B_BIT]) begin
        dataB_q <= slotBSample;
      end
    end
  end

  // New sample wins over a same-cycle clear
  // write-one clear of flags
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flags_q <= 8'h00;
    end else begin
      flags_q[oms_pkg::INT_A_BIT] <= (flags_q[oms_pkg::INT_A_BIT]
        && !(wrStatus && wrData[oms_pkg::INT_A_BIT]))
        || (slotAValid && mode_q == oms_pkg::MS_NORMAL);
      flags_q[oms_pkg::INT_B_BIT] <= (flags_q[oms_pkg::INT_B_BIT]
        && !(wrStatus && wrData[oms_pkg::INT_B_BIT]))
        || (slotBValid && mode_q == oms_pkg::MS_NORMAL);
    end
  end

  always_comb begin
    unique case (regAddr)
      oms_pkg::ADDR_STATUS: rdData = {levelBytes, flags_q};
      oms_pkg::ADDR_MODE: rdData = {14'h0000, modeCode};
      oms_pkg::ADDR_FMT: rdData = fmt_q;
      oms_pkg::ADDR_LED1: rdData = led1_q;
      oms_pkg::ADDR_LED2: rdData = led2_q;
      oms_pkg::ADDR_LED3: rdData = led3_q;
      oms_pkg::ADDR_CLKCTL: rdData = clkCtl_q;
      oms_pkg::ADDR_DATACTL: rdData = dataCtl_q;
      oms_pkg::ADDR_FIFO: rdData = (count_q != 7'h00) ? fifoMem_q[rdPtr_q] : 16'h0000;
      oms_pkg::ADDR_DATA_A: rdData = dataA_q;
      oms_pkg::ADDR_DATA_B: rdData = dataB_q;
      default: rdData = 16'h0000;
    endcase
  end
endmodule

// [rtl/oms_pkg.sv]
// Purpose: Shared constants and types for the operating-mode sequencer
// Assumes: 8-bit register addresses, 16-bit register words
// Notes: Mode codes are the values software writes to the mode register
package oms_pkg;
  // Register map
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_FMT = 8'h11;
  localparam logic [7:0] ADDR_LED1 = 8'h22;
  localparam logic [7:0] ADDR_LED2 = 8'h23;
  localparam logic [7:0] ADDR_LED3 = 8'h24;
  localparam logic [7:0] ADDR_CLKCTL = 8'h4b;
  localparam logic [7:0] ADDR_DATACTL = 8'h5f;
  localparam logic [7:0] ADDR_FIFO = 8'h60;
  localparam logic [7:0] ADDR_DATA_A = 8'h64;
  localparam logic [7:0] ADDR_DATA_B = 8'h68;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Mode codes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_PROGRAM = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;

  // Field positions
  localparam int CLK_EN_BIT = 7;
  localparam int FIFO_ACC_BIT = 0;
  localparam int HOLD_A_BIT = 1;
  localparam int HOLD_B_BIT = 2;
  localparam int FIFO_CLR_BIT = 15;
  localparam int INT_A_BIT = 5;
  localparam int INT_B_BIT = 6;
  localparam int SLEW_LSB = 4;
  localparam int SLEW_MSB = 6;
  localparam int FMT_A_LSB = 2;
  localparam int FMT_A_MSB = 4;
  localparam int FMT_B_LSB = 6;
  localparam int FMT_B_MSB = 8;
  localparam int LEVEL_LSB = 8;

  // FIFO geometry: 128 bytes held as 16-bit words
  localparam int FIFO_BYTES = 128;
  localparam int WORD_BYTES = 2;
  localparam int FIFO_WORDS = FIFO_BYTES / WORD_BYTES;
  localparam logic [6:0] FIFO_WORDS_W = 7'(FIFO_WORDS);

  // Slow sample clock derived from the system clock
  localparam int SYS_PERIOD_NS = 10;
  localparam int SLOW_PERIOD_NS = 31250;
  localparam int SLOW_DIV_CYCLES = SLOW_PERIOD_NS / SYS_PERIOD_NS;
  localparam logic [11:0] SLOW_DIV_LAST = 12'(SLOW_DIV_CYCLES - 1);

  typedef enum logic [2:0] {
    MS_STANDBY = 3'b001,
    MS_PROGRAM = 3'b010,
    MS_NORMAL = 3'b100
  } oms_mode_t;

  typedef enum logic [4:0] {
    PS_IDLE = 5'b00001,
    PS_ADDR = 5'b00010,
    PS_REG = 5'b00100,
    PS_WDATA = 5'b01000,
    PS_RDATA = 5'b10000
  } oms_port_state_t;
endpackage

// [testbench/oms_host_model.sv]
// Purpose: Host writing and reading registers over the two-wire port
// Assumes: Data line pulled up; device bus address 0x30
// Notes: sda moves two cycles after scl falls, away from scl edges
`timescale 1ns/10ps
module oms_host_model (
  input wire logic sys_clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaPull
);
  localparam int H = 10;
  int ackMiss = 0;
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic xfer(input logic pull, output logic seen);
    sdaPull = pull;
    tk(H);
    scl = 1'b1;
    tk(H / 2);
    seen = sdaLine;
    tk(H / 2);
    scl = 1'b0;
    tk(2);
  endtask
  // Also a repeated start: sda is let go before scl rises
  task automatic start();
    sdaPull = 1'b0;
    tk(H);
    scl = 1'b1;
    tk(H);
    sdaPull = 1'b1;
    tk(H);
    scl = 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sdaPull = 1'b1;
    tk(H);
    scl = 1'b1;
    tk(H);
    sdaPull = 1'b0;
    tk(H);
  endtask
  task automatic put(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(!b[i], s);
    xfer(1'b0, s);
    if (s) ackMiss++;
  endtask
  // NACK on the last byte so the device frees sda for the stop
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(1'b0, b[i]);
    xfer(!last, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    start();
    put(8'h60);
    put(a);
    put(d[15:8]);
    put(d[7:0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    start();
    put(8'h60);
    put(a);
    start();
    put(8'h61);
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    stop();
  endtask
endmodule

// [testbench/oms_mode_sequencer_chk.sv]
// Purpose: Port-level checks on the mode machine and its lock-up
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Bound into every oms_mode_sequencer instance
`timescale 1ns/10ps
module oms_mode_sequencer_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] modeCode,
  input wire logic sampleClockRunning,
  input wire logic lockedUp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [11:0] sinceChg_q;
  logic [1:0] modePrev_q;
  // Saturating count of cycles since the last mode change
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sinceChg_q <= 12'h000;
      modePrev_q <= oms_pkg::MODE_STANDBY;
    end else begin
      modePrev_q <= modeCode;
      if (modeCode != modePrev_q) sinceChg_q <= 12'h000;
      else if (sinceChg_q != 12'hfff) sinceChg_q <= sinceChg_q + 12'h001;
    end
  end
  a_reset_standby: assert property ($past(reset) |-> modeCode == 2'h0 && !lockedUp)
    else $error("mode not standby after reset");
  a_tick_spacing: assert property ($changed(modeCode) |-> sinceChg_q >= oms_pkg::SLOW_DIV_LAST)
    else $error("mode changes closer than one slow tick");
  a_stopped_still: assert property (!sampleClockRunning [*3] |=> $stable(modeCode))
    else $error("mode moved with sample clock stopped");
  a_legal_steps: assert property ($changed(modeCode) |-> $past(modeCode) == 2'h1 || modeCode == 2'h1)
    else $error("mode step skips program mode");
  a_lock_freezes: assert property (lockedUp [*3] |=> $stable(modeCode))
    else $error("mode moved while locked");
  a_lock_sticky: assert property (lockedUp |=> lockedUp)
    else $error("lock released without reset");
  a_lock_cause: assert property ($rose(lockedUp) |-> !sampleClockRunning && modeCode != 2'h0)
    else $error("lock without clock stop outside standby");
  a_lock_soon: assert property ($fell(sampleClockRunning) && modeCode != 2'h0 |-> ##[0:3] lockedUp)
    else $error("clock stop outside standby did not lock");
  a_mode_code: assert property (modeCode != 2'h3)
    else $error("undefined mode code");
  cover property (modeCode == oms_pkg::MODE_NORMAL);
  cover property ($rose(lockedUp));
  cover property ($changed(modeCode) && modeCode == oms_pkg::MODE_STANDBY);
endmodule
bind oms_mode_sequencer oms_mode_sequencer_chk u_chk (.sys_clk(sys_clk), .reset(reset),
  .modeCode(modeCode), .sampleClockRunning(sampleClockRunning), .lockedUp(lockedUp));

// [testbench/test_oms_mode_sequencer.sv]
// Purpose: Self-checking bench for the operating-mode sequencer
// Assumes: Host model on the register port, slot pulses from the bench
// Notes: Each mode change costs one slow tick, so waits are long
`timescale 1ns/10ps
module test_oms_mode_sequencer;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sdaIn, sdaOut, sdaOe, hostPull, running, lockedUp;
  logic aVal = 1'b0, bVal = 1'b0;
  logic [15:0] aSmp = 16'h0000, bSmp = 16'h0000;
  logic [2:0] aAvg = 3'h1, bAvg = 3'h2;
  logic [1:0] modeCode;
  logic [2:0] slew1, slew2, slew3;
  logic [31:0] seed = 32'h2182;
  int n_fail = 0, checks = 0;
  // Wired-AND of both open-drain pullers over the pull-up
  assign sdaIn = !(hostPull || sdaOe);
  initial forever #5 sys_clk = ~sys_clk;
  oms_host_model host (.sys_clk(sys_clk), .sdaLine(sdaIn), .scl(scl), .sdaPull(hostPull));
  oms_mode_sequencer DUT (.sys_clk(sys_clk), .reset(reset), .sclIn(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .slotAValid(aVal), .slotASample(aSmp),
    .slotBValid(bVal), .slotBSample(bSmp), .slotAAvgFactor(aAvg), .slotBAvgFactor(bAvg),
    .modeCode(modeCode), .sampleClockRunning(running), .lockedUp(lockedUp),
    .ledSlewOne(slew1), .ledSlewTwo(slew2), .ledSlewThree(slew3));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] stat(input int words, input logic fa, input logic fb);
    return {8'(2 * words), 1'b0, fb, fa, 5'h00};
  endfunction
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.rd(a, d);
    check(d, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int i;
    checks++;
    for (i = 0; i < 3400 && modeCode !== m; i++) @(negedge sys_clk);
    if (i == 3400) begin
      n_fail++;
      $display("Error at %0t: mode %h not reached", $time, m);
      tally_and_finish();
    end
  endtask
  task automatic shot(input logic isB);
    seed = lfsr(seed);
    if (isB) bSmp = seed[15:0];
    else aSmp = seed[15:0];
    aVal = !isB;
    bVal = isB;
    idle(1);
    aVal = 1'b0;
    bVal = 1'b0;
    idle(1);
  endtask
  initial begin
    logic [15:0] first;
    idle(5);
    reset = 1'b0;
    idle(4);
    check(modeCode, oms_pkg::MODE_STANDBY);
    rdc(oms_pkg::ADDR_MODE, 16'h0000);
    // Program request ahead of the clock enable must be held back
    host.wr(oms_pkg::ADDR_MODE, 16'h0001);
    idle(3400);
    check(modeCode, oms_pkg::MODE_STANDBY);
    host.wr(oms_pkg::ADDR_CLKCTL, 16'h0080);
    check(running, 1'b1);
    wait_mode(oms_pkg::MODE_PROGRAM);
    rdc(oms_pkg::ADDR_MODE, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      host.wr(oms_pkg::ADDR_LED1 + 8'(i), seed[15:0]);
      idle(2);
      check(i == 0 ? slew1 : i == 1 ? slew2 : slew3, seed[6:4]);
      rdc(oms_pkg::ADDR_LED1 + 8'(i), seed[15:0]);
    end
    host.wr(oms_pkg::ADDR_FMT, 16'h0044);
    host.wr(oms_pkg::ADDR_MODE, 16'h0002);
    wait_mode(oms_pkg::MODE_NORMAL);
    // Unequal averaging keeps slot B out of the FIFO
    shot(1'b0);
    first = aSmp;
    shot(1'b0);
    shot(1'b0);
    shot(1'b1);
    rdc(oms_pkg::ADDR_STATUS, stat(3, 1'b1, 1'b1));
    rdc(oms_pkg::ADDR_DATA_B, bSmp);
    host.wr(oms_pkg::ADDR_STATUS, 16'h00ff);
    rdc(oms_pkg::ADDR_STATUS, stat(3, 1'b0, 1'b0));
    bAvg = 3'h1;
    // Pairs fill 63 words; the last pair needs two with one free and is dropped
    for (int i = 0; i < 31; i++) begin
      shot(1'b0);
      shot(1'b1);
    end
    rdc(oms_pkg::ADDR_STATUS, stat(63, 1'b1, 1'b1));
    host.wr(oms_pkg::ADDR_DATACTL, 16'h0001);
    host.wr(oms_pkg::ADDR_DATACTL, 16'h0001);
    rdc(oms_pkg::ADDR_FIFO, first);
    rdc(oms_pkg::ADDR_STATUS, stat(62, 1'b1, 1'b1));
    host.wr(oms_pkg::ADDR_STATUS, 16'h80ff);
    rdc(oms_pkg::ADDR_STATUS, 16'h0000);
    host.wr(oms_pkg::ADDR_MODE, 16'h0000);
    idle(3400);
    check(modeCode, oms_pkg::MODE_NORMAL);
    host.wr(oms_pkg::ADDR_MODE, 16'h0001);
    wait_mode(oms_pkg::MODE_PROGRAM);
    host.wr(oms_pkg::ADDR_MODE, 16'h0000);
    wait_mode(oms_pkg::MODE_STANDBY);
    rdc(8'h7f, 16'h0000);
    // Clock left running in standby, as a careful host does
    host.wr(oms_pkg::ADDR_MODE, 16'h0001);
    wait_mode(oms_pkg::MODE_PROGRAM);
    host.wr(oms_pkg::ADDR_CLKCTL, 16'h0000);
    check(lockedUp, 1'b1);
    // Clock back on; the lock must still refuse standby
    host.wr(oms_pkg::ADDR_CLKCTL, 16'h0080);
    host.wr(oms_pkg::ADDR_MODE, 16'h0000);
    idle(3400);
    check(modeCode, oms_pkg::MODE_PROGRAM);
    check(16'(host.ackMiss), 16'h0000);
    check(sdaOut, 1'b0);
    tally_and_finish();
  end
endmodule
